// [rtl/switch_expander_pkg.sv]
// Package for the I2C switch expander: bus address, register map, reset values,
// and the bit positions of the switch enables.
// Assumes the users import the whole package.
package switch_expander_pkg;
   // ***************************************************************
   // Bus address and register map
   // ***************************************************************
   localparam logic [6:0] dev_addr = 7'h22;
   localparam logic [7:0] port_a_direction_off = 8'h00;
   localparam logic [7:0] port_b_direction_off = 8'h01;
   localparam logic [7:0] port_a_switch_outputs_off = 8'h12;
   localparam logic [7:0] port_b_switch_outputs_off = 8'h13;
   localparam logic [7:0] direction_reset = 8'hFF;
   localparam logic [7:0] outputs_reset = 8'h00;
   localparam logic [7:0] unmapped_read = 8'h00;
   // ***************************************************************
   // Port A bit positions
   // ***************************************************************
   localparam int eeprom_select_bit = 0;
   localparam int pushbutton_bit = 1;
   localparam int card_socket_route_bit = 2;
   localparam int usb_bridge_enable_bit = 3;
   localparam int can_enable_bit = 4;
   localparam int audio_converter_reset_bit = 5;
   localparam int dac_path_enable_bit = 6;
   localparam int adc_path_enable_bit = 7;
   // ***************************************************************
   // Port B bit positions
   // ***************************************************************
   localparam int octal_flash_select_bit = 0;
   localparam int spdif_coax_enable_bit = 1;
   localparam int spdif_optical_enable_bit = 2;
   localparam int audio_jack_select_bit = 3;
   localparam int media_link_mode_select_bit = 4;
   localparam int fast_ethernet_signal_enable_bit = 5;
   localparam int fast_ethernet_phy_reset_bit = 6;
   localparam int gigabit_phy_reset_bit = 7;

   typedef enum logic [2:0] {
      st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack, st_wdata, st_wdata_ack, st_rdata
   } bus_state_type;
endpackage : switch_expander_pkg

// [rtl/pin_driver_if.sv]
// Interface carrying direction and output bytes from the register core to the pin driver.
// Assumes one driver (core) and one consumer (pin driver).
`timescale 1ns/1ps
interface pin_driver_if;
   logic [7:0] dir_a;
   logic [7:0] dir_b;
   logic [7:0] out_a;
   logic [7:0] out_b;
   modport core (output dir_a, dir_b, out_a, out_b);
   modport pins (input dir_a, dir_b, out_a, out_b);
endinterface : pin_driver_if

// [rtl/switch_pin_driver.sv]
// Pin driver for the sixteen switch enables.
// Assumes board pull resistors set the level of any pin left undriven.
`timescale 1ns/1ps
module switch_pin_driver
   import switch_expander_pkg::*;
(
   pin_driver_if.pins regs, // Register values
   output logic [7:0] pa_out, // Port A pin level
   output logic [7:0] pa_oe, // Port A drive enable
   output logic [7:0] pb_out, // Port B pin level
   output logic [7:0] pb_oe // Port B drive enable
);
   // ***************************************************************
   // Drive
   // ***************************************************************
   // Direction zero means output; a one leaves the pin to its pull
   always_comb begin
      pa_out = regs.out_a;
      pb_out = regs.out_b;
      pa_oe = ~regs.dir_a;
      pb_oe = ~regs.dir_b;
   end
endmodule : switch_pin_driver

// [rtl/softconfig_switch_expander.sv]
// I2C-addressed 16-bit switch expander: two-wire slave, register file, pin drive.
// Assumes scl and sda come from the board asynchronously; sda is open drain.
//
// Overview of operation
// - Two 8-bit switch output registers, port A at 0x12, port B at 0x13.
// - After reset all pins are inputs and drive nothing.
// - Device answers on two-wire bus at 7-bit address 0x22.
// - Both switch output registers reset to 0x00.
// - A0 gates EEPROM chip select, A1 gates both pushbuttons; default high.
// - A2 routes SPI to card socket, A3 enables USB bridge; default high.
// - A4 enables both CAN transceiver signal sets; default high.
// - A5 resets audio converters, A6 enables DAC, A7 ADC; default high.
// - B0 gates octal flash chip select; default low.
// - B1 and B2 enable coaxial and optical S/PDIF; default high.
// - B3 selects audio jack as input or output; default high.
// - B4 selects media link three-pin or six-pin mode; default high.
// - B5 enables reduced Ethernet signals; default low.
// - B6 drives fast Ethernet transceiver reset; no default.
// - B7 drives gigabit transceiver reset; default high.
// - A driven one opens the switch path; pulled low keeps it closed.
`timescale 1ns/1ps
module softconfig_switch_expander
   import switch_expander_pkg::*;
(
   input wire logic clk, // 250 MHz system clock
   input wire logic nrst, // Async reset, active low
   input wire logic scl_in, // Two-wire clock pin
   input wire logic sda_in, // Two-wire data pin level
   output logic sda_out, // Data drive level, always low
   output logic sda_oe, // Data drive enable, high pulls low
   output logic [7:0] pa_out, // Port A pin levels
   output logic [7:0] pa_oe, // Port A drive enables
   output logic [7:0] pb_out, // Port B pin levels
   output logic [7:0] pb_oe // Port B drive enables
);
   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic scl_prev_r;
   logic sda_prev_r;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Two flops before any logic; the prev flops sit behind the second stage
   // Reset to the idle high level so that releasing reset never fakes a start
   // condition or a falling bus clock.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
         scl_prev_r <= scl_sync_r[1];
         sda_prev_r <= sda_sync_r[1];
      end
   end

   // Bus conditions from the clean second stage
   // Start and stop need the bus clock high on both samples, so data changes made
   // while the clock is low never look like bus conditions.
   always_comb begin
      scl_rise = scl_sync_r[1] & ~scl_prev_r;
      scl_fall = ~scl_sync_r[1] & scl_prev_r;
      start_seen = scl_sync_r[1] & scl_prev_r & sda_prev_r & ~sda_sync_r[1];
      stop_seen = scl_sync_r[1] & scl_prev_r & ~sda_prev_r & sda_sync_r[1];
   end

   // ***************************************************************
   // Register read mux
   // ***************************************************************
   logic [7:0] dir_a_r;
   logic [7:0] dir_b_r;
   logic [7:0] out_a_r;
   logic [7:0] out_b_r;

   // Read data is fetched when the address acknowledge ends, so a write landing
   // earlier in the same transfer is already visible.
   // Unmapped offsets read as zero and ignore writes
   function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] da,
                                           input logic [7:0] db, input logic [7:0] oa,
                                           input logic [7:0] ob);
      case (idx)
         port_a_direction_off: reg_read = da;
         port_b_direction_off: reg_read = db;
         port_a_switch_outputs_off: reg_read = oa;
         port_b_switch_outputs_off: reg_read = ob;
         default: reg_read = unmapped_read;
      endcase
   endfunction : reg_read

   // ***************************************************************
   // Two-wire slave state machine
   // ***************************************************************
   // Limitations: no clock stretching, so the host must keep every bus clock
   // phase above about eight system clocks; the acknowledge and each read bit
   // appear one clock after the synchronised falling edge, two to three after the pin edge.
   // The register pointer advances after every written data byte and every read byte the
   // master acknowledges, so a burst walks through the map; unmapped offsets read zero.
   // A repeated start is taken in any state and restarts address decoding.
   bus_state_type state_r, state_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [3:0] bitcnt_r, bitcnt_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic sda_oe_r, sda_oe_nxt;
   logic rd_r, rd_nxt;
   logic wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_val;

   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bitcnt_nxt = bitcnt_r;
      ptr_nxt = ptr_r;
      sda_oe_nxt = sda_oe_r;
      rd_nxt = rd_r;
      wr_en = 1'b0;
      wr_idx = ptr_r;
      wr_val = shift_r;
      if (start_seen) begin
         // Repeated start re-enters address phase
         state_nxt = st_addr;
         bitcnt_nxt = 4'h0;
         sda_oe_nxt = 1'b0;
      end else if (stop_seen) begin
         state_nxt = st_idle;
         sda_oe_nxt = 1'b0;
      end else begin
         case (state_r)
            st_idle: begin
               sda_oe_nxt = 1'b0;
            end
            st_addr, st_reg, st_wdata: begin
               // Sample data on rising clock edge, MSB first
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_sync_r[1]};
                  bitcnt_nxt = bitcnt_r + 4'h1;
               end
               if (scl_fall && bitcnt_r == 4'h8) begin
                  bitcnt_nxt = 4'h0;
                  if (state_r == st_addr) begin
                     if (shift_r[7:1] == dev_addr) begin
                        rd_nxt = shift_r[0];
                        sda_oe_nxt = 1'b1;
                        state_nxt = st_addr_ack;
                     end else begin
                        state_nxt = st_idle; // Not ours: stay silent
                     end
                  end else if (state_r == st_reg) begin
                     ptr_nxt = shift_r;
                     sda_oe_nxt = 1'b1;
                     state_nxt = st_reg_ack;
                  end else begin
                     wr_en = 1'b1;
                     sda_oe_nxt = 1'b1;
                     state_nxt = st_wdata_ack;
                  end
               end
            end
            st_addr_ack: begin
               if (scl_fall) begin
                  if (rd_r) begin
                     shift_nxt = reg_read(ptr_r, dir_a_r, dir_b_r, out_a_r, out_b_r);
                     sda_oe_nxt = ~shift_nxt[7]; // Open drain: pull low for a zero
                     bitcnt_nxt = 4'h0;
                     state_nxt = st_rdata;
                  end else begin
                     sda_oe_nxt = 1'b0;
                     state_nxt = st_reg;
                  end
               end
            end
            st_reg_ack, st_wdata_ack: begin
               // Pointer advances past each written data byte, not past the register byte
               if (scl_fall) begin
                  sda_oe_nxt = 1'b0;
                  if (state_r == st_wdata_ack) begin
                     ptr_nxt = ptr_r + 8'h01;
                  end
                  state_nxt = st_wdata;
               end
            end
            st_rdata: begin
               // Drive MSB first; release for master ack on ninth bit
               // Master ack keeps the burst going from the advanced pointer
               if (scl_fall) begin
                  bitcnt_nxt = bitcnt_r + 4'h1;
                  if (bitcnt_r == 4'h7) begin
                     sda_oe_nxt = 1'b0;
                  end else if (bitcnt_r == 4'h8) begin
                     if (sda_prev_r) begin
                        state_nxt = st_idle; // Master nack ends the read
                     end else begin
                        ptr_nxt = ptr_r + 8'h01;
                        shift_nxt = reg_read(ptr_r + 8'h01, dir_a_r, dir_b_r,
                                             out_a_r, out_b_r);
                        sda_oe_nxt = ~shift_nxt[7];
                        bitcnt_nxt = 4'h0;
                     end
                  end else begin
                     shift_nxt = {shift_r[6:0], 1'b0};
                     sda_oe_nxt = ~shift_r[6];
                  end
               end
            end
            default: begin
               state_nxt = st_idle;
               sda_oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // Bus state registers; reset leaves the data line released
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= st_idle;
         shift_r <= 8'h00;
         bitcnt_r <= 4'h0;
         ptr_r <= 8'h00;
         sda_oe_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bitcnt_r <= bitcnt_nxt;
         ptr_r <= ptr_nxt;
         sda_oe_r <= sda_oe_nxt;
         rd_r <= rd_nxt;
      end
   end

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [7:0] dir_a_nxt, dir_b_nxt, out_a_nxt, out_b_nxt;

   // Write strobe lasts one clock, at the falling bus clock ending a data byte.
   // Direction ones leave a pin on its board pull, hence the all-ones reset:
   // nothing is overridden until software clears a bit.
   // Values hold until the host rewrites them
   always_comb begin
      dir_a_nxt = dir_a_r;
      dir_b_nxt = dir_b_r;
      out_a_nxt = out_a_r;
      out_b_nxt = out_b_r;
      if (wr_en) begin
         case (wr_idx)
            port_a_direction_off: dir_a_nxt = wr_val;
            port_b_direction_off: dir_b_nxt = wr_val;
            port_a_switch_outputs_off: out_a_nxt = wr_val;
            port_b_switch_outputs_off: out_b_nxt = wr_val;
            default: ;
         endcase
      end
   end

   // Reset state: all pins input, all switch outputs zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir_a_r <= direction_reset;
         dir_b_r <= direction_reset;
         out_a_r <= outputs_reset;
         out_b_r <= outputs_reset;
      end else begin
         dir_a_r <= dir_a_nxt;
         dir_b_r <= dir_b_nxt;
         out_a_r <= out_a_nxt;
         out_b_r <= out_b_nxt;
      end
   end

   // ***************************************************************
   // Pin drive
   // ***************************************************************
   // Switch meanings are board wiring: a one opens the FET path
   // Drive kept in its own module so a board variant can change drive polarity
   // without touching the bus logic.
   pin_driver_if pins_if ();
   assign pins_if.dir_a = dir_a_r;
   assign pins_if.dir_b = dir_b_r;
   assign pins_if.out_a = out_a_r;
   assign pins_if.out_b = out_b_r;

   switch_pin_driver u_pins (
      .regs(pins_if.pins),
      .pa_out(pa_out),
      .pa_oe(pa_oe),
      .pb_out(pb_out),
      .pb_oe(pb_oe)
   );

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_r;
endmodule : softconfig_switch_expander

// [tb/switch_expander_props.sv]
// Checker for the expander pins and the bus data line.
// Assumes bus phases of at least eight clocks, as the host model makes them.
`timescale 1ns/1ps
module switch_expander_props
   import switch_expander_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic scl_in, // Bus clock
   input wire logic sda_in, // Bus data wire
   input wire logic sda_out, // Data drive level
   input wire logic sda_oe, // Data drive enable
   input wire logic [7:0] pa_out, // Port A levels
   input wire logic [7:0] pa_oe, // Port A enables
   input wire logic [7:0] pb_out, // Port B levels
   input wire logic [7:0] pb_oe // Port B enables
);
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Bus clock high long enough for the sync flops to settle
   sequence scl_high_run;
      scl_in [*5];
   endsequence
   // A pulled-low bit must stay pulled for eight clocks after it rises
   sequence ack_body;
      sda_oe [*8];
   endsequence
   AST_RST_DIR: assert property ($rose(nrst) |-> pa_oe == 8'h00 && pb_oe == 8'h00)
      else $error("pins driven right after reset");
   AST_RST_OUT: assert property ($rose(nrst) |-> pa_out == 8'h00 && pb_out == 8'h00)
      else $error("output registers not zero after reset");
   AST_SDA_LEVEL: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   AST_HOLD_A: assert property (!$stable(pa_out) |-> !scl_in && !$past(scl_in))
      else $error("port A changed outside a byte end");
   AST_HOLD_B: assert property (!$stable(pb_out) |-> !scl_in && !$past(scl_in))
      else $error("port B changed outside a byte end");
   AST_HOLD_DIR: assert property (scl_in [*3] |-> $stable({pa_oe, pb_oe}))
      else $error("direction changed while the bus clock stood");
   AST_ACK_RISE: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data pulled low while bus clock high");
   AST_ACK_HOLD: assert property ($rose(sda_oe) |-> ack_body)
      else $error("pulled-low bit released too early");
   AST_SDA_STABLE: assert property (scl_high_run |-> $stable(sda_oe))
      else $error("data drive changed while bus clock high");
endmodule : switch_expander_props

bind softconfig_switch_expander switch_expander_props u_props (.clk(clk), .nrst(nrst),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe));

// [tb/twi_host_model.sv]
// Two-wire host model that writes and reads the expander registers.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module twi_host_model
   import switch_expander_pkg::*;
(
   input wire logic clk, // Bench clock
   input wire logic sda_line, // Resolved data wire
   output logic scl, // Bus clock, push driven
   output logic sda_rel // High releases the data wire
);
   // ***************************************************************
   // Bus phases
   // ***************************************************************
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // Ten clocks a phase stays clear of the sync latency
   task automatic half();
      repeat (10) @(posedge clk);
      #1;
   endtask : half
   task automatic start_cond();
      half();
      sda_rel = 1'b0;
      half();
      scl = 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      sda_rel = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_rel = 1'b1;
      half();
   endtask : stop_cond
   // Data set in the low phase, sampled at the end of the high phase
   task automatic bit_xfer(input logic b, output logic s);
      sda_rel = b;
      half();
      scl = 1'b1;
      half();
      s = sda_line;
      scl = 1'b0;
   endtask : bit_xfer
   task automatic byte_xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], s);
         q[i] = s;
      end
      bit_xfer(1'b1, s);
      ack = !s;
   endtask : byte_xfer
   // Address, register, data, then stop
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d,
                            output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start_cond();
      byte_xfer({dev, 1'b0}, q, a0);
      byte_xfer(r, q, a1);
      byte_xfer(d, q, a2);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask : write_reg
   // Pointer set by a write, then one byte read and refused
   task automatic read_reg(input logic [7:0] r, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      start_cond();
      byte_xfer({dev_addr, 1'b0}, q, a);
      byte_xfer(r, q, a);
      stop_cond();
      start_cond();
      byte_xfer({dev_addr, 1'b1}, q, a);
      byte_xfer(8'hFF, d, a);
      stop_cond();
   endtask : read_reg
endmodule : twi_host_model

// [tb/softconfig_switch_expander_tb.sv]
// Self-checking bench for the switch expander over its two-wire port.
// Assumes the host model makes all bus traffic; the data wire has a pull-up.
`timescale 1ns/1ps
module softconfig_switch_expander_tb
   import switch_expander_pkg::*;
;
   logic clk, nrst, scl, sda_rel, sda_out, sda_oe, ok;
   logic [7:0] pa_out, pa_oe, pb_out, pb_oe, rd;
   wire sda_line;
   int n_errors;
   int tests_run;
   // Open-drain wire: high unless a party pulls it low
   assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
   softconfig_switch_expander dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
      .pb_oe(pb_oe));
   twi_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
   // ***************************************************************
   // Clock, checks and verdict
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      $display("Error watchdog expected end seen hang");
      end_sim();
   end
   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      nrst = 1'b0;
      n_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      check("pa_oe", 8'h00, pa_oe);
      check("pb_oe", 8'h00, pb_oe);
      check("pa_out", 8'h00, pa_out);
      host.read_reg(port_b_switch_outputs_off, rd);
      check("read b", 8'h00, rd);
      host.read_reg(port_a_direction_off, rd);
      check("read dir a", direction_reset, rd);
      $display("Test reset done");
      // Value written while input must not drive the pin
      host.write_reg(dev_addr, port_a_switch_outputs_off, 8'hA5, ok);
      check("ack", 8'h01, {7'h00, ok});
      check("pa_oe input", 8'h00, pa_oe);
      host.write_reg(dev_addr, port_a_direction_off, 8'h00, ok);
      host.write_reg(dev_addr, port_b_direction_off, 8'h0F, ok);
      check("pa_oe", 8'hFF, pa_oe);
      check("pb_oe", 8'hF0, pb_oe);
      check("pa_out held", 8'hA5, pa_out);
      $display("Test direction done");
      // Walk a single one through every switch of both ports
      host.write_reg(dev_addr, port_b_direction_off, 8'h00, ok);
      for (int i = 0; i < 8; i++) begin
         host.write_reg(dev_addr, port_a_switch_outputs_off, 8'h01 << i, ok);
         host.write_reg(dev_addr, port_b_switch_outputs_off, 8'h80 >> i, ok);
         check("pa_out bit", 8'h01 << i, pa_out);
         check("pb_out bit", 8'h80 >> i, pb_out);
      end
      $display("Test switches done");
      // Foreign address and unmapped offset are ignored
      host.write_reg(dev_addr ^ 7'h01, port_a_switch_outputs_off, 8'h3C, ok);
      check("foreign ack", 8'h00, {7'h00, ok});
      check("pa_out kept", 8'h80, pa_out);
      host.write_reg(dev_addr, 8'h05, 8'h5A, ok);
      host.read_reg(8'h05, rd);
      check("unmapped", unmapped_read, rd);
      host.read_reg(port_b_switch_outputs_off, rd);
      check("read b back", 8'h01, rd);
      $display("Test refusal done");
      // Reset in mid-run returns every pin to input
      @(posedge clk);
      #1 nrst = 1'b0;
      repeat (6) @(posedge clk);
      check("pa_oe rst", 8'h00, pa_oe);
      check("pb_out rst", 8'h00, pb_out);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      host.read_reg(port_b_switch_outputs_off, rd);
      check("read b rst", outputs_reset, rd);
      $display("Test second reset done");
      end_sim();
   end
endmodule : softconfig_switch_expander_tb
